// ---- include/pmc_defines.svh ----
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PMC_OFF_PWR_CTRL 12'h000
`define PMC_OFF_PWR_CFG 12'h004
`define PMC_OFF_CLK_SEL 12'h008
`define PMC_OFF_PERIPH_EN 12'h00C
`define PMC_OFF_IRQ_STAT 12'h010
`define PMC_OFF_IRQ_MASK 12'h014
`define PMC_OFF_WAKE_EN 12'h018
`define PMC_OFF_TK_COUNT 12'h01C
`define PMC_OFF_TK_ALARM 12'h020
`define PMC_OFF_STATUS 12'h024
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMC_PWR_CTRL_IDLE 0
`define PMC_PWR_CTRL_STOP 1
`define PMC_PWR_CFG_SUSPEND 0
`define PMC_PWR_CFG_SLEEP 1
// Wake/status bit positions
`define PMC_EV_ALARM 0
`define PMC_EV_TKFAIL 1
`define PMC_EV_CAPSENSE 2
`define PMC_EV_PORTMATCH 3
`define PMC_EV_CMP_RISE 4
`define PMC_EV_PINA 5
`define PMC_EV_PINB 6
`define PMC_EV_COUNT 7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMC_RST_CLK_SRC 2'h0
`define PMC_RST_CLK_DIV 3'h3
`define PMC_RST_PERIPH_EN 8'h00
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define PMC_OSC_SETTLE_CYC 16
`define PMC_TK_MISS_CYC 64
`endif

// ---- include/pmc_pkg.sv ----
package pmc_pkg;
   // Clock source codes
   typedef enum logic [1:0] {
      PMC_SRC_LOWPWR = 2'h0,
      PMC_SRC_FAST = 2'h1,
      PMC_SRC_SLOW = 2'h2,
      PMC_SRC_EXT = 2'h3
   } pmc_src_t;
   // Power sequencer states, one-hot
   typedef enum logic [5:0] {
      PMC_ST_NORMAL = 6'h01,
      PMC_ST_IDLE = 6'h02,
      PMC_ST_SUSPEND = 6'h04,
      PMC_ST_SLEEP = 6'h08,
      PMC_ST_STOP = 6'h10,
      PMC_ST_WAKE = 6'h20
   } pmc_state_t;
   // Clock choice carried together
   typedef struct packed {
      logic [2:0] div;
      pmc_src_t src;
   } pmc_clk_cfg_t;
   // Power-domain enables carried together
   typedef struct packed {
      logic core_clk_en;
      logic periph_clk_en;
      logic osc_en;
      logic main_pwr_en;
      logic pins_hold;
   } pmc_pwr_t;
endpackage : pmc_pkg

// ---- src/pmc_power_ctrl.sv ----
`timescale 1ns/1ns
// Functional notes
// - Normal mode keeps core and all peripherals clocked and running.
// - Idle bit halts core, peripherals clocked; any interrupt wakes it.
// - Software picks fast or low-power oscillator first; suspend halts core, peripherals, oscillators.
// - Suspend exits on alarm, timekeeper fail, capsense, port match, comparator rise.
// - Stop shuts all internal power, pins hold; only reset exits.
// - Software disables analog first; sleep powers down most nets, keeps selected circuits.
// - Sleep retains pins, RAM, registers; wakes on alarm, fail, port match, comparator.
// - Each digital peripheral clock gated off when not enabled.
// - After reset system clock is low-power oscillator divided by 8.
// - Divider offers eight power-of-two ratios, 1 through 128.
// - Four sources: low-power, fast, slow internal oscillators and external input.
// - Timekeeper is a 32-bit counter independent of core, alive in lowest mode.
// - Missing timekeeper crystal clock raises a failure event.
// - Alarm and fail events can wake the device or request a reset.
// - Sixteen pins share a port-match source; two pins have own vectors.
`include "pmc_defines.svh"
module pmc_power_ctrl
   import pmc_pkg::*;
#(
   parameter int NUM_PERIPH = 8,
   parameter int NUM_PORT = 16,
   parameter int OSC_SETTLE = `PMC_OSC_SETTLE_CYC,
   parameter int TK_MISS = `PMC_TK_MISS_CYC
)(
   input wire logic clock,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Asynchronous event pins
   input wire logic tk_xtal_clk,
   input wire logic capsense_irq,
   input wire logic cmp_out,
   input wire logic [NUM_PORT-1:0] port_pins,
   input wire logic pin_a,
   input wire logic pin_b,
   input wire logic periph_irq,
   // Power and clock controls
   output pmc_clk_cfg_t clk_cfg,
   output pmc_pwr_t pwr,
   output logic [NUM_PERIPH-1:0] periph_clk_en,
   output logic tk_reset_req,
   output logic irq
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   localparam int NSYNC = NUM_PORT + 5;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic [NSYNC-1:0] sync3;
   wire logic [NSYNC-1:0] raw_in = {port_pins, tk_xtal_clk, capsense_irq, cmp_out,
                                    pin_a, pin_b};
   // Two stages before any logic, third stage only for edge detection
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end
      else
      begin
         sync1 <= raw_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   wire logic [NUM_PORT-1:0] port_s = sync2[NSYNC-1:5];
   wire logic xtal_edge = sync2[4] ^ sync3[4];
   wire logic cs_rise = sync2[3] & ~sync3[3];
   wire logic cmp_rise = sync2[2] & ~sync3[2];
   wire logic pina_rise = sync2[1] & ~sync3[1];
   wire logic pinb_rise = sync2[0] & ~sync3[0];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   pmc_state_t state;
   pmc_state_t next_state;
   logic [1:0] pwr_ctrl;
   logic [1:0] pwr_cfg;
   logic [NUM_PERIPH-1:0] periph_en;
   logic [`PMC_EV_COUNT-1:0] irq_stat;
   logic [`PMC_EV_COUNT-1:0] irq_mask;
   logic [`PMC_EV_COUNT-1:0] wake_en;
   logic tk_reset_en;
   logic [NUM_PORT-1:0] port_match_val;
   logic [NUM_PORT-1:0] port_match_mask;
   logic [31:0] tk_count;
   logic [31:0] tk_alarm;
   logic [15:0] miss_cnt;
   logic [15:0] settle_cnt;
   logic tk_failed;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   // Writes land only at the edge that completes the transfer, never in the wait state
   wire logic wr = psel & penable & pwrite & pready;
   wire logic sel_ctrl = paddr == `PMC_OFF_PWR_CTRL;
   wire logic sel_cfg = paddr == `PMC_OFF_PWR_CFG;
   wire logic sel_clk = paddr == `PMC_OFF_CLK_SEL;
   wire logic sel_pen = paddr == `PMC_OFF_PERIPH_EN;
   wire logic sel_stat = paddr == `PMC_OFF_IRQ_STAT;
   wire logic sel_mask = paddr == `PMC_OFF_IRQ_MASK;
   wire logic sel_wake = paddr == `PMC_OFF_WAKE_EN;
   wire logic sel_cnt = paddr == `PMC_OFF_TK_COUNT;
   wire logic sel_alarm = paddr == `PMC_OFF_TK_ALARM;
   wire logic sel_sts = paddr == `PMC_OFF_STATUS;
   wire logic sel_any = sel_ctrl | sel_cfg | sel_clk | sel_pen | sel_stat | sel_mask |
                        sel_wake | sel_cnt | sel_alarm | sel_sts;
   // Mode writes only accepted while running, so a pending write cannot re-enter
   wire logic run_st = state == PMC_ST_NORMAL;
   wire logic wr_ctrl = wr & sel_ctrl & run_st;
   wire logic wr_cfg = wr & sel_cfg & run_st;
   // Suspend is refused unless the clock runs from a permitted oscillator
   wire logic src_ok = clk_cfg.src == PMC_SRC_FAST || clk_cfg.src == PMC_SRC_LOWPWR;
   // Read-back mirrors the write layout, so software can save and restore a register
   wire logic [31:0] rd_mux =
      sel_ctrl ? {30'h0, pwr_ctrl} :
      sel_cfg ? {30'h0, pwr_cfg} :
      sel_clk ? {27'h0, clk_cfg} :
      sel_pen ? {{(32-NUM_PERIPH){1'b0}}, periph_en} :
      sel_stat ? {25'h0, irq_stat} :
      sel_mask ? {25'h0, irq_mask} :
      sel_wake ? {tk_reset_en, 8'h0, wake_en, port_match_mask} :
      sel_cnt ? tk_count :
      sel_alarm ? tk_alarm :
      sel_sts ? {25'h0, tk_failed, state} : 32'h0;

   // ----------------------------------------
   // Events
   // ----------------------------------------
   wire logic port_hit = |((port_s ^ port_match_val) & port_match_mask);
   wire logic alarm_hit = tk_count == tk_alarm;
   wire logic fail_hit = miss_cnt == TK_MISS[15:0];
   wire logic [`PMC_EV_COUNT-1:0] ev = {pinb_rise, pina_rise, cmp_rise, port_hit,
                                         cs_rise, fail_hit, alarm_hit};
   wire logic [`PMC_EV_COUNT-1:0] stat_clr = (wr & sel_stat) ? pwdata[6:0] : '0;
   wire logic any_irq = |(irq_stat & irq_mask) | periph_irq;
   // Suspend wakes on all five sources, sleep on four (no capsense)
   wire logic susp_wake = |(ev[4:0] & wake_en[4:0]);
   wire logic sleep_wake = |({ev[4:3], ev[1:0]} & {wake_en[4:3], wake_en[1:0]});

   // ----------------------------------------
   // Power sequencer
   // ----------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         PMC_ST_NORMAL:
         begin
            if (wr_ctrl && pwdata[`PMC_PWR_CTRL_STOP])
               next_state = PMC_ST_STOP;
            else if (wr_cfg && pwdata[`PMC_PWR_CFG_SLEEP])
               next_state = PMC_ST_SLEEP;
            else if (wr_cfg && pwdata[`PMC_PWR_CFG_SUSPEND] && src_ok)
               next_state = PMC_ST_SUSPEND;
            else if (wr_ctrl && pwdata[`PMC_PWR_CTRL_IDLE])
               next_state = PMC_ST_IDLE;
         end
         PMC_ST_IDLE:
            if (any_irq)
               next_state = PMC_ST_NORMAL;
         PMC_ST_SUSPEND:
            if (susp_wake)
               next_state = PMC_ST_WAKE;
         PMC_ST_SLEEP:
            if (sleep_wake)
               next_state = PMC_ST_WAKE;
         PMC_ST_STOP:
            next_state = PMC_ST_STOP;
         PMC_ST_WAKE:
            if (settle_cnt == 16'h0)
               next_state = PMC_ST_NORMAL;
         default:
            next_state = PMC_ST_NORMAL;
      endcase
   end

   // State and oscillator settle counter
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= PMC_ST_NORMAL;
         settle_cnt <= 16'h0;
      end
      else
      begin
         state <= next_state;
         if (state != PMC_ST_WAKE)
            settle_cnt <= OSC_SETTLE[15:0];
         else if (settle_cnt != 16'h0)
            settle_cnt <= settle_cnt - 16'h1;
      end
   end

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pwr_ctrl <= 2'h0;
         pwr_cfg <= 2'h0;
         clk_cfg <= '{div: `PMC_RST_CLK_DIV, src: PMC_SRC_LOWPWR};
         periph_en <= `PMC_RST_PERIPH_EN;
         irq_mask <= '0;
         wake_en <= '0;
         tk_reset_en <= 1'b0;
         port_match_val <= '0;
         port_match_mask <= '0;
         tk_alarm <= 32'hFFFFFFFF;
      end
      else
      begin
         // Mode bits self-clear on return, so the resumed code sees them low
         if (wr_ctrl)
            pwr_ctrl <= pwdata[1:0];
         else if (next_state == PMC_ST_NORMAL)
            pwr_ctrl <= 2'h0;
         if (wr_cfg)
            pwr_cfg <= pwdata[1:0];
         else if (next_state == PMC_ST_NORMAL)
            pwr_cfg <= 2'h0;
         if (wr && sel_clk)
            clk_cfg <= pmc_clk_cfg_t'(pwdata[4:0]);
         if (wr && sel_pen)
            periph_en <= pwdata[NUM_PERIPH-1:0];
         if (wr && sel_mask)
            irq_mask <= pwdata[6:0];
         if (wr && sel_wake)
         begin
            port_match_mask <= pwdata[15:0];
            wake_en <= pwdata[22:16];
            tk_reset_en <= pwdata[31];
         end
         if (wr && sel_alarm)
            tk_alarm <= pwdata;
      end
   end

   // Sticky status: a new event wins over a clear in the same cycle
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         irq_stat <= '0;
      else
         irq_stat <= (irq_stat & ~stat_clr) | ev;
   end

   // ----------------------------------------
   // Timekeeper and missing-clock detector
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         tk_count <= 32'h0;
         miss_cnt <= 16'h0;
         tk_failed <= 1'b0;
         tk_reset_req <= 1'b0;
      end
      else
      begin
         // Counts crystal edges in every mode, stop included
         if (wr && sel_cnt)
            tk_count <= pwdata;
         else if (xtal_edge)
            tk_count <= tk_count + 32'h1;
         if (xtal_edge)
            miss_cnt <= 16'h0;
         else if (!fail_hit)
            miss_cnt <= miss_cnt + 16'h1;
         tk_failed <= fail_hit;
         tk_reset_req <= tk_reset_en & (alarm_hit | fail_hit);
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PERIPH; gi++)
      begin : g_gate
         // Gated per peripheral, and off whenever digital logic is halted
         always_ff @(posedge clock or negedge nrst)
         begin
            if (!nrst)
               periph_clk_en[gi] <= 1'b0;
            else
               periph_clk_en[gi] <= periph_en[gi] &
                  (next_state == PMC_ST_NORMAL || next_state == PMC_ST_IDLE);
         end
      end
   endgenerate

   // Power controls follow the next state so they change with it
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pwr <= '{core_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1,
                  main_pwr_en: 1'b1, pins_hold: 1'b0};
         irq <= 1'b0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pwr.core_clk_en <= next_state == PMC_ST_NORMAL;
         pwr.periph_clk_en <= next_state == PMC_ST_NORMAL || next_state == PMC_ST_IDLE;
         pwr.osc_en <= !(next_state == PMC_ST_SUSPEND || next_state == PMC_ST_SLEEP ||
                         next_state == PMC_ST_STOP);
         pwr.main_pwr_en <= !(next_state == PMC_ST_SLEEP ||
                              next_state == PMC_ST_STOP);
         pwr.pins_hold <= next_state == PMC_ST_SLEEP || next_state == PMC_ST_STOP;
         irq <= |(irq_stat & irq_mask);
         // One wait state: ready in the second access cycle
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~sel_any;
         // Read data only while selected, so an idle bus shows zero
         prdata <= (psel & ~pwrite) ? rd_mux : 32'h0;
      end
   end
endmodule : pmc_power_ctrl

// ---- test/pmc_power_checker.sv ----
`timescale 1ns/1ns
// ------------------
// Port checks
// ------------------
module pmc_power_checker
   import pmc_pkg::*;
#(
   parameter int NUM_PERIPH = 8,
   parameter int OSC_SETTLE = 16
)(
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic periph_irq,
   input wire pmc_clk_cfg_t clk_cfg,
   input wire pmc_pwr_t pwr,
   input wire logic [NUM_PERIPH-1:0] periph_clk_en
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);
   // Answer one edge after the access phase, and for one cycle only
   a_ready_on_time: assert property (psel && penable && !pready |=> pready)
      else $error("late pready");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   // A running core means every domain is up and pins are free
   a_core_all_on: assert property (pwr.core_clk_en |-> pwr[3:0] == 4'hE)
      else $error("core runs in low power");
   a_idle_wakes: assert property (!pwr.core_clk_en && pwr.periph_clk_en && periph_irq
      |-> ##[1:4] pwr.core_clk_en)
      else $error("idle not left");
   a_osc_off_halt: assert property (!pwr.osc_en |-> !pwr.core_clk_en && !pwr.periph_clk_en)
      else $error("clocks on without oscillator");
   a_pins_hold: assert property (!pwr.main_pwr_en |-> pwr.pins_hold)
      else $error("pins released");
   a_reset_clock: assert property ($rose(nrst) |-> clk_cfg == {3'h3, PMC_SRC_LOWPWR})
      else $error("wrong reset clock");
   // Clock choice moves only when software writes it; gates also move when the peripheral domain switches
   a_clk_by_write: assert property ($changed(clk_cfg) |->
      $past(psel && penable && pready && pwrite && paddr == 12'h008))
      else $error("clock choice moved");
   a_gate_by_write: assert property ($changed(periph_clk_en) && $stable(pwr.periph_clk_en) |->
      $past(psel && penable && pready && pwrite && paddr == 12'h00C, 2))
      else $error("gate moved");
   a_gate_halted: assert property (!pwr.periph_clk_en |-> periph_clk_en == '0)
      else $error("gate open while halted");
   // Core may restart only after the oscillator had time to settle
   a_settle_first: assert property ($rose(pwr.core_clk_en) && !$past(pwr.periph_clk_en)
      |-> $past(pwr.osc_en, OSC_SETTLE + 1))
      else $error("core before oscillator settled");
endmodule : pmc_power_checker
bind pmc_power_ctrl pmc_power_checker #(.NUM_PERIPH(NUM_PERIPH), .OSC_SETTLE(OSC_SETTLE)) u_chk (
   .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .periph_irq(periph_irq),
   .clk_cfg(clk_cfg), .pwr(pwr), .periph_clk_en(periph_clk_en)
);

// ---- test/pmc_wake_src.sv ----
`timescale 1ns/1ns
// ------------------
// Wake-event sources
// ------------------
module pmc_wake_src (
   input wire logic clock,
   input wire logic xtal_run,
   input wire logic [4:0] fire,
   input wire logic [15:0] port_sel,
   output logic tk_xtal_clk,
   output logic capsense_irq,
   output logic cmp_out,
   output logic pin_a,
   output logic pin_b,
   output logic [15:0] port_pins
);
   logic [1:0] div_cnt = 2'h0;
   logic [3:0] left [5] = '{default: 4'h0};
   logic [4:0] lvl;
   initial tk_xtal_clk = 1'b0;
   // Crystal stands still when stopped, which the miss detector must catch
   always @(posedge clock)
   begin
      div_cnt <= div_cnt + 2'h1;
      if (xtal_run && div_cnt == 2'h3)
         tk_xtal_clk <= ~tk_xtal_clk;
      for (int i = 0; i < 5; i++)
         left[i] <= fire[i] ? 4'h6 : left[i] - 4'(left[i] != 4'h0);
   end
   // Six-cycle levels so the synchroniser cannot miss them
   always_comb
      for (int i = 0; i < 5; i++)
         lvl[i] = left[i] != 4'h0;
   assign {pin_b, pin_a, cmp_out, capsense_irq} = lvl[3:0];
   assign port_pins = lvl[4] ? port_sel : 16'h0000;
endmodule : pmc_wake_src

// ---- test/tb.sv ----
`timescale 1ns/1ns
// ------------------
// Power controller bench
// ------------------
module tb;
   import pmc_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic periph_irq = 1'b0;
   logic xtal_run = 1'b1;
   logic [4:0] fire = 5'h00;
   logic [15:0] port_sel = 16'h0001;
   logic [31:0] prdata, rd, expv;
   logic pready, pslverr, err, irq, tk_reset_req, tk_xtal_clk, capsense_irq, cmp_out, pin_a, pin_b;
   logic [15:0] port_pins;
   logic [7:0] periph_clk_en;
   pmc_clk_cfg_t clk_cfg;
   pmc_pwr_t pwr;
   int n_fail = 0;
   int check_count = 0;
   int cycles = 0;
   int evs [6] = '{0, 1, 4, 1, 4, 0};
   always #5 clock = ~clock;
   pmc_power_ctrl #(.OSC_SETTLE(2), .TK_MISS(8)) u_pmc_power_ctrl (
      .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tk_xtal_clk(tk_xtal_clk), .capsense_irq(capsense_irq), .cmp_out(cmp_out),
      .port_pins(port_pins), .pin_a(pin_a), .pin_b(pin_b), .periph_irq(periph_irq),
      .clk_cfg(clk_cfg), .pwr(pwr), .periph_clk_en(periph_clk_en),
      .tk_reset_req(tk_reset_req), .irq(irq)
   );
   pmc_wake_src u_pmc_wake_src (
      .clock(clock), .xtal_run(xtal_run), .fire(fire), .port_sel(port_sel),
      .tk_xtal_clk(tk_xtal_clk), .capsense_irq(capsense_irq), .cmp_out(cmp_out),
      .pin_a(pin_a), .pin_b(pin_b), .port_pins(port_pins)
   );
   function automatic logic [31:0] cfg_word(input int s, input int v);
      return {27'h0, 3'(v), 2'(s)};
   endfunction : cfg_word
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %0h seen %0h", name, e, g);
      end
   endtask : chk
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (n == 16)
         n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Two idle edges so registered effects of the write have settled
      repeat (2) @(posedge clock);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(name, e, rd);
   endtask : rchk
   task automatic ev(input int i);
      fire[i] <= 1'b1;
      @(posedge clock);
      fire[i] <= 1'b0;
      @(posedge clock);
   endtask : ev
   // Bounded wait, since a lost wake would otherwise hang the run
   task automatic wait_core(input logic e);
      int n;
      n = 0;
      while (pwr.core_clk_en !== e && n < 30)
      begin
         @(posedge clock);
         n++;
      end
      chk("core clock", 32'(e), 32'(pwr.core_clk_en));
   endtask : wait_core
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         n_fail++;
         wrap_up();
      end
   end
   initial
   begin
      void'($urandom(25));
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      chk("clk_cfg", 32'h0000000C, 32'(clk_cfg));
      chk("pwr", 32'h0000001E, 32'(pwr));
      rchk("alarm", 12'h020, 32'hFFFFFFFF);
      for (int s = 0; s < 4; s++)
         for (int v = 0; v < 8; v++)
         begin
            wr(12'h008, cfg_word(s, v));
            chk("clk_cfg", cfg_word(s, v), 32'(clk_cfg));
         end
      // Suspend while running from the external source must be refused
      wr(12'h004, 32'h1);
      chk("refused", 32'h1, 32'(pwr.core_clk_en));
      rchk("mode bits", 12'h004, 32'h0);
      wr(12'h008, cfg_word(0, 3));
      repeat (4)
      begin
         expv = 32'($urandom_range(255));
         wr(12'h00C, expv);
         chk("gate", expv, 32'(periph_clk_en));
      end
      apb(1'b0, 12'h100, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      chk("unmapped", 32'h0, rd);
      // Pin a unmasked, pin b masked
      wr(12'h014, 32'h20);
      ev(2);
      ev(3);
      repeat (12) @(posedge clock);
      chk("irq", 32'h1, 32'(irq));
      rchk("stat", 12'h010, 32'h60);
      wr(12'h010, 32'h20);
      chk("irq", 32'h0, 32'(irq));
      wr(12'h010, 32'h7F);
      wr(12'h000, 32'h1);
      chk("idle", 32'h1, 32'(pwr[4:3]));
      periph_irq <= 1'b1;
      wait_core(1'b1);
      periph_irq <= 1'b0;
      // Suspend against capsense, comparator, port match; sleep against comparator, port match, then capsense, which must not wake sleep
      wr(12'h018, 32'h007FFFFF);
      rchk("wake", 12'h018, 32'h007FFFFF);
      for (int k = 0; k < 6; k++)
      begin
         port_sel <= 16'($urandom) | 16'h0001;
         wr(12'h004, (k < 3) ? 32'h1 : 32'h2);
         chk("halted", 32'h0, 32'(pwr.core_clk_en | (k < 3 && pwr.osc_en)));
         ev(evs[k]);
         if (k == 5)
         begin
            repeat (20) @(posedge clock);
            chk("asleep", 32'h0, 32'(pwr.core_clk_en));
            ev(1);
         end
         wait_core(1'b1);
         rchk("mode bits", 12'h004, 32'h0);
      end
      wr(12'h01C, 32'h0);
      wr(12'h020, 32'h8);
      wr(12'h010, 32'h7F);
      repeat (40) @(posedge clock);
      apb(1'b0, 12'h01C, 32'h0);
      chk("counting", 32'h1, 32'(rd > 32'h8));
      apb(1'b0, 12'h010, 32'h0);
      chk("alarm hit", 32'h1, 32'(rd[0]));
      chk("no reset", 32'h0, 32'(tk_reset_req));
      wr(12'h018, 32'h807FFFFF);
      xtal_run <= 1'b0;
      repeat (30) @(posedge clock);
      chk("reset req", 32'h1, 32'(tk_reset_req));
      apb(1'b0, 12'h024, 32'h0);
      chk("failed", 32'h1, 32'(rd[6]));
      wr(12'h000, 32'h2);
      chk("stop", 32'h1, 32'(pwr[1:0]));
      ev(1);
      repeat (20) @(posedge clock);
      chk("still off", 32'h0, 32'(pwr.core_clk_en));
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      chk("pwr", 32'h0000001E, 32'(pwr));
      wrap_up();
   end
endmodule : tb
